/* logic/bmoc_top.sv */
// Operation
// - reset output held low 16 cycles if hold-select set, else 4064 cycles.
// - watchdog on after reset when option set, never in bootstrap mode.
// - watchdog stopped in wait unless watchdog-in-wait option set.
// - port B/C pull-downs per pin, only while pin is an input.
// - eeprom split: first 32 bytes never protected, upper 224 protectable.
// - protect bit zero blocks upper-part erase/program; one allows all.
// - protect bit accepts a zero write only while latch-enable set.
// - upper-part protection ignored in bootstrap mode.
// - security bit zero refuses entry to any non-user mode.
// - security bit change takes effect only from next reset.
// - oscillator divide-by-two forced in bootstrap mode.
// - bootstrap starts from the dedicated bootstrap reset vector.
// - mode pins two to four sampled at reset release choose bootstrap function.
// - after copying code, first compare output driven high, except while fetching data or verifying, where it carries address bit 13.
// - erase verify: any nonzero byte lights error and halts, else pass.
// - wait while mode pin one low, then erase eeprom about 2.5 s, except in MD_PROG_NO_EE mode.
// - unerased eeprom byte after erase lights error, clears pass and halts before programming.
// - mode pin two low selects 5 ms programming time.
// - ascending walk, skip gaps, 16-byte blocks, skip fully erased data.
// - 15-bit address out on port B, port C, compares; data on port A.
// - after programming, compare with source; pass stays on or error lights.
// - latch-enable cleared by stop and reset; clear means read condition.
`default_nettype none
`include "bmoc_defs.svh"
module bmoc_top #(
  parameter int unsigned EE_ERASE_CYC = `BMOC_EE_ERASE_MS * `BMOC_CLK_KHZ,
  parameter int unsigned PROG_CYC = `BMOC_PROG_MS * `BMOC_CLK_KHZ,
  parameter int unsigned PROG_ALT_CYC = `BMOC_PROG_MS * `BMOC_CLK_KHZ,
  parameter logic [7:0] OPT_INIT = 8'h03,
  parameter logic [7:0] FOB_INIT = 8'h00
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [14:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core status
  input wire logic stop_mode,
  input wire logic wait_mode,
  output logic reset_out_n,
  output logic wdog_enable,
  output logic wdog_run,
  output logic osc_div2,
  output logic boot_mode,
  output logic [14:0] boot_vector,
  output logic ram_jump,
  // pull-downs
  input wire logic [7:0] portb_dir,
  input wire logic [7:0] portc_dir,
  output logic [7:0] portb_pulldown,
  output logic [7:0] portc_pulldown,
  // cpu eeprom access check
  input wire logic ee_req,
  input wire logic [7:0] ee_req_offset,
  output logic ee_grant,
  // bootstrap pins
  input wire logic irq_high_volt,
  input wire logic capture_in_one,
  input wire logic mode_sel_one,
  input wire logic mode_sel_two,
  input wire logic mode_sel_three,
  input wire logic mode_sel_four,
  input wire logic [7:0] porta_in,
  input wire logic handshake_line_b,
  output logic handshake_line_a,
  output logic [7:0] portb_out,
  output logic [4:0] portc_out,
  output logic compare_out_one,
  output logic compare_out_two,
  output logic pass_led,
  output logic fail_led,
  // memory array port
  output logic [14:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic ep_prog,
  output logic ee_prog,
  output logic ee_erase
);
  import bmoc_pkg::*;

  logic [7:0] opt_q = OPT_INIT;
  logic lat_q;
  logic sec_eff_q;
  logic [11:0] hold_q;
  logic started_q;
  logic boot_q;
  bmoc_mode_t mode_q;
  bmoc_state_t st_q;
  logic [14:0] addr_q;
  logic [7:0] data_q;
  logic [3:0] idx_q;
  logic nz_q;
  logic vfy_q;
  logic [26:0] tmr_q;
  logic copied_q;
  logic [7:0] blk_mem [16];
  logic hs_a_q;
  logic [7:0] rdata_q;
  logic upper_ok;
  logic [26:0] prog_cyc;
  logic [14:0] next_addr;
  logic addr_last;
  logic in_ee;

  assign prog_cyc = mode_sel_two ? 27'(PROG_ALT_CYC) : 27'(PROG_CYC);
  assign in_ee = (addr_q <= `BMOC_EE_LAST);
  assign addr_last = (addr_q == `BMOC_EP_LAST);
  assign next_addr = (addr_q == `BMOC_EE_LAST) ? `BMOC_EP_FIRST : addr_q + 15'h0001;

  // reset hold counter, started on reset release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 12'h000;
      reset_out_n <= 1'b0;
    end else if (!reset_out_n) begin
      hold_q <= hold_q + 12'h001;
      if (hold_q == (FOB_INIT[`BMOC_FOB_RHOLD] ? `BMOC_HOLD_SHORT : `BMOC_HOLD_LONG)
          - 12'h001) begin
        reset_out_n <= 1'b1;
      end
    end
  end

  // mode capture in first cycle after reset release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      started_q <= 1'b0;
      boot_q <= 1'b0;
      mode_q <= MD_ERASE_PROG;
      sec_eff_q <= 1'b1;
    end else if (!started_q) begin
      started_q <= 1'b1;
      sec_eff_q <= opt_q[`BMOC_OPT_SEC];
      boot_q <= irq_high_volt && capture_in_one && opt_q[`BMOC_OPT_SEC];
      if (mode_sel_four && mode_sel_three) begin
        mode_q <= MD_SERIAL;
      end else if (mode_sel_four) begin
        mode_q <= MD_VERIFY;
      end else if (mode_sel_three && mode_sel_two) begin
        mode_q <= MD_JUMP_RAM;
      end else if (mode_sel_three) begin
        mode_q <= MD_PROG_NO_EE;
      end else begin
        mode_q <= MD_ERASE_PROG;
      end
    end
  end

  assign boot_mode = boot_q;
  assign osc_div2 = boot_q;
  assign boot_vector = `BMOC_BOOT_VEC;
  assign wdog_enable = FOB_INIT[`BMOC_FOB_WATCHDOG_ON_AFTER_RESET] && !boot_q;
  assign wdog_run = wdog_enable && (!wait_mode || FOB_INIT[`BMOC_FOB_WATCHDOG_IN_WAIT]);
  assign portb_pulldown = {8{FOB_INIT[`BMOC_FOB_PORTB_PULLDOWN_EN]}} & ~portb_dir;
  assign portc_pulldown = {8{FOB_INIT[`BMOC_FOB_PORTC_PULLDOWN_EN]}} & ~portc_dir;

  // upper eeprom part writable
  assign upper_ok = opt_q[`BMOC_OPT_UNPROT] || boot_q;
  assign ee_grant = ee_req && lat_q
    && ((ee_req_offset < `BMOC_EE_LOW_SIZE) || upper_ok);

  // eeprom latch enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lat_q <= 1'b0;
    end else if (stop_mode) begin
      lat_q <= 1'b0;
    end else if (reg_wr && reg_addr == `BMOC_CTRL_ADDR) begin
      lat_q <= reg_wdata[`BMOC_CTRL_LAT];
    end
  end

  // options byte, non-volatile: reset leaves it alone so a new lock bites at next reset
  always_ff @(posedge ref_clk) begin
    if (reg_wr && reg_addr == `BMOC_OPT_ADDR) begin
      opt_q[`BMOC_OPT_SEC] <= reg_wdata[`BMOC_OPT_SEC];
      if (reg_wdata[`BMOC_OPT_UNPROT] || lat_q) begin
        opt_q[`BMOC_OPT_UNPROT] <= reg_wdata[`BMOC_OPT_UNPROT];
      end
    end
  end

  // register read, one cycle later
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `BMOC_CTRL_ADDR: reg_rdata <= {6'h00, lat_q, 1'b0};
        `BMOC_STAT_ADDR: reg_rdata <= {3'h0, sec_eff_q, boot_q, copied_q,
                                        fail_led, pass_led};
        `BMOC_OPT_ADDR: reg_rdata <= {6'h00, opt_q[1:0]};
        `BMOC_FOB_ADDR: reg_rdata <= {3'h0, FOB_INIT[4:0]};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // 16-byte block buffer
  always_ff @(posedge ref_clk) begin
    if (st_q == ST_RELEASE && !vfy_q && !in_ee && !handshake_line_b) begin
      blk_mem[addr_q[3:0]] <= data_q;
    end
  end

  // bootstrap sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_RESET;
      addr_q <= 15'h0000;
      data_q <= 8'h00;
      idx_q <= 4'h0;
      nz_q <= 1'b0;
      vfy_q <= 1'b0;
      tmr_q <= 27'h0000000;
      copied_q <= 1'b0;
      hs_a_q <= 1'b0;
      pass_led <= 1'b0;
      fail_led <= 1'b0;
      ram_jump <= 1'b0;
      mem_addr <= 15'h0000;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      ep_prog <= 1'b0;
      ee_prog <= 1'b0;
      ee_erase <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      ep_prog <= 1'b0;
      ee_prog <= 1'b0;
      case (st_q)
        ST_RESET: begin
          if (started_q) begin
            st_q <= boot_q ? ST_COPY : ST_USER;
          end
        end
        ST_COPY: begin
          copied_q <= 1'b1;
          if (mode_q == MD_JUMP_RAM || mode_q == MD_SERIAL) begin
            ram_jump <= 1'b1;
            st_q <= ST_RAM;
          end else if (mode_q == MD_VERIFY) begin
            vfy_q <= 1'b1;
            addr_q <= `BMOC_EE_FIRST;
            st_q <= ST_FETCH;
          end else begin
            addr_q <= `BMOC_EP_FIRST;
            st_q <= ST_ERV_RD;
          end
        end
        ST_ERV_RD: begin
          mem_addr <= addr_q;
          st_q <= ST_ERV_CK;
        end
        ST_ERV_CK: begin
          if (mem_rdata != `BMOC_EP_ERASED) begin
            fail_led <= 1'b1;
            st_q <= ST_FAIL;
          end else if (addr_last) begin
            pass_led <= 1'b1;
            st_q <= ST_WAIT_SEL1;
          end else begin
            addr_q <= addr_q + 15'h0001;
            st_q <= ST_ERV_RD;
          end
        end
        ST_WAIT_SEL1: begin
          if (mode_sel_one) begin
            if (mode_q == MD_PROG_NO_EE) begin
              addr_q <= `BMOC_EP_FIRST;
              st_q <= ST_FETCH;
            end else begin
              ee_erase <= 1'b1;
              tmr_q <= 27'(EE_ERASE_CYC);
              st_q <= ST_EE_ERASE;
            end
          end
        end
        ST_EE_ERASE: begin
          if (tmr_q <= 27'h0000001) begin
            ee_erase <= 1'b0;
            addr_q <= `BMOC_EE_FIRST;
            st_q <= ST_EE_RD;
          end else begin
            tmr_q <= tmr_q - 27'h0000001;
          end
        end
        ST_EE_RD: begin
          mem_addr <= addr_q;
          st_q <= ST_EE_CK;
        end
        ST_EE_CK: begin
          if (mem_rdata != `BMOC_EE_ERASED) begin
            fail_led <= 1'b1;
            pass_led <= 1'b0;
            st_q <= ST_FAIL;
          end else if (addr_q == `BMOC_EE_LAST) begin
            addr_q <= `BMOC_EE_FIRST;
            st_q <= ST_FETCH;
          end else begin
            addr_q <= addr_q + 15'h0001;
            st_q <= ST_EE_RD;
          end
        end
        ST_FETCH: begin
          hs_a_q <= 1'b1;
          if (hs_a_q && handshake_line_b) begin
            data_q <= porta_in;
            hs_a_q <= 1'b0;
            st_q <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!handshake_line_b) begin
            if (vfy_q) begin
              mem_addr <= addr_q;
              st_q <= ST_VFY_RD;
            end else if (in_ee) begin
              if (data_q == `BMOC_EE_ERASED) begin
                addr_q <= next_addr;
                st_q <= ST_FETCH;
              end else begin
                mem_addr <= addr_q;
                mem_wdata <= data_q;
                mem_we <= 1'b1;
                ee_prog <= 1'b1;
                tmr_q <= prog_cyc;
                st_q <= ST_PROG_WAIT;
              end
            end else if (addr_q[3:0] != 4'hF) begin
              nz_q <= nz_q || (data_q != `BMOC_EP_ERASED);
              addr_q <= next_addr;
              st_q <= ST_FETCH;
            end else if (!nz_q && data_q == `BMOC_EP_ERASED) begin
              addr_q <= addr_q + 15'h0001;
              st_q <= addr_last ? ST_VFY_RD : ST_FETCH;
              if (addr_last) begin
                vfy_q <= 1'b1;
                addr_q <= (mode_q == MD_PROG_NO_EE) ? `BMOC_EP_FIRST
                                                   : `BMOC_EE_FIRST;
                st_q <= ST_FETCH;
              end
            end else begin
              idx_q <= 4'h0;
              st_q <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          mem_addr <= {addr_q[14:4], idx_q};
          mem_wdata <= blk_mem[idx_q];
          mem_we <= 1'b1;
          idx_q <= idx_q + 4'h1;
          if (idx_q == 4'hF) begin
            ep_prog <= 1'b1;
            tmr_q <= prog_cyc;
            st_q <= ST_PROG_WAIT;
          end
        end
        ST_PROG_WAIT: begin
          nz_q <= 1'b0;
          if (tmr_q <= 27'h0000001) begin
            if (addr_last) begin
              vfy_q <= 1'b1;
              addr_q <= (mode_q == MD_PROG_NO_EE) ? `BMOC_EP_FIRST
                                                 : `BMOC_EE_FIRST;
            end else begin
              addr_q <= next_addr;
            end
            st_q <= ST_FETCH;
          end else begin
            tmr_q <= tmr_q - 27'h0000001;
          end
        end
        ST_VFY_RD: begin
          st_q <= ST_VFY_CK;
        end
        ST_VFY_CK: begin
          if (mem_rdata != data_q) begin
            fail_led <= 1'b1;
            pass_led <= 1'b0;
            st_q <= ST_FAIL;
          end else if (addr_last) begin
            pass_led <= 1'b1;
            st_q <= ST_PASS;
          end else begin
            addr_q <= next_addr;
            st_q <= ST_FETCH;
          end
        end
        ST_PASS, ST_FAIL, ST_RAM, ST_USER: begin
          st_q <= st_q;
        end
        default: begin
          st_q <= ST_FAIL;
        end
      endcase
    end
  end

  // address on port B, port C and compares during transfer
  assign handshake_line_a = hs_a_q;
  assign portb_out = addr_q[7:0];
  assign portc_out = addr_q[12:8];
  assign compare_out_one = (st_q == ST_FETCH || st_q == ST_RELEASE || vfy_q)
    ? addr_q[13] : copied_q;
  assign compare_out_two = addr_q[14];
endmodule : bmoc_top
`default_nettype wire

/* pkg/bmoc_defs.svh */
`ifndef BMOC_DEFS_SVH
`define BMOC_DEFS_SVH
`define BMOC_CTRL_ADDR 15'h0007
`define BMOC_STAT_ADDR 15'h0008
`define BMOC_OPT_ADDR 15'h0100
`define BMOC_FOB_ADDR 15'h7FDE
`define BMOC_OPT_UNPROT 1
`define BMOC_OPT_SEC 0
`define BMOC_CTRL_LAT 1
`define BMOC_FOB_RHOLD 4
`define BMOC_FOB_WATCHDOG_ON_AFTER_RESET 3
`define BMOC_FOB_WATCHDOG_IN_WAIT 2
`define BMOC_FOB_PORTB_PULLDOWN_EN 1
`define BMOC_FOB_PORTC_PULLDOWN_EN 0
`define BMOC_HOLD_SHORT 12'h010
`define BMOC_HOLD_LONG 12'hFE0
`define BMOC_BOOT_VEC 15'h7FEE
`define BMOC_EE_FIRST 15'h0100
`define BMOC_EE_LAST 15'h01FF
`define BMOC_EE_LOW_SIZE 8'h20
`define BMOC_EP_FIRST 15'h0400
`define BMOC_EP_LAST 15'h7DFF
`define BMOC_EP_ERASED 8'h00
`define BMOC_EE_ERASED 8'hFF
`define BMOC_CLK_KHZ 40000
`define BMOC_EE_ERASE_MS 2500
`define BMOC_PROG_MS 5
`endif

/* pkg/bmoc_pkg.sv */
`default_nettype none
package bmoc_pkg;
  typedef enum logic [4:0] {
    ST_RESET, ST_COPY, ST_ERV_RD, ST_ERV_CK, ST_WAIT_SEL1, ST_EE_ERASE,
    ST_EE_RD, ST_EE_CK, ST_FETCH, ST_RELEASE, ST_LOAD, ST_PROG_WAIT,
    ST_VFY_RD, ST_VFY_CK, ST_PASS, ST_FAIL, ST_RAM, ST_USER
  } bmoc_state_t;
  typedef enum logic [2:0] {
    MD_ERASE_PROG, MD_PROG_NO_EE, MD_VERIFY, MD_JUMP_RAM, MD_SERIAL
  } bmoc_mode_t;
endpackage : bmoc_pkg
`default_nettype wire

/* testbench/bmoc_monitor.sv */
`default_nettype none
`include "bmoc_defs.svh"
module bmoc_monitor #(
  parameter logic [7:0] FOB_INIT = 8'h00
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // core status
  input wire logic reset_out_n,
  input wire logic wait_mode,
  input wire logic stop_mode,
  // register port, then watchdog and boot status
  input wire logic [14:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic wdog_enable,
  input wire logic wdog_run,
  input wire logic osc_div2,
  input wire logic boot_mode,
  input wire logic [14:0] boot_vector,
  // pull-downs and eeprom check
  input wire logic [7:0] portb_dir,
  input wire logic [7:0] portc_dir,
  input wire logic [7:0] portb_pulldown,
  input wire logic [7:0] portc_pulldown,
  input wire logic ee_req,
  input wire logic [7:0] ee_req_offset,
  input wire logic ee_grant,
  // bootstrap pins
  input wire logic handshake_line_a,
  input wire logic handshake_line_b,
  input wire logic fail_led,
  input wire logic compare_out_one
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = FOB_INIT[4] ? 16 : 4064;
  logic lat_m_q;
  // expected latch enable, from register writes and stop
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) lat_m_q <= 1'b0;
    else if (stop_mode) lat_m_q <= 1'b0;
    else if (reg_wr && reg_addr == `BMOC_CTRL_ADDR) lat_m_q <= reg_wdata[`BMOC_CTRL_LAT];
  end
  logic [11:0] hold_cnt_q;
  // cycles since reset release, saturating
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hold_cnt_q <= 12'h000;
    else if (hold_cnt_q != 12'hFFF) hold_cnt_q <= hold_cnt_q + 12'h001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_hold_low; hold_cnt_q < 12'(HOLD - 1) |-> !reset_out_n; endproperty
  a_hold_low: assert property (p_hold_low) else $error("reset out early");
  property p_hold_rise; $rose(reset_out_n) |-> hold_cnt_q <= 12'(HOLD + 2); endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("reset out late");
  property p_wdog_boot; boot_mode |-> !wdog_enable; endproperty
  a_wdog_boot: assert property (p_wdog_boot) else $error("watchdog on in boot");
  property p_wdog_wait; wait_mode && !FOB_INIT[2] |-> !wdog_run; endproperty
  a_wdog_wait: assert property (p_wdog_wait) else $error("watchdog runs in wait");
  property p_wdog_on; wdog_enable && (!wait_mode || FOB_INIT[2]) |-> wdog_run; endproperty
  a_wdog_on: assert property (p_wdog_on) else $error("watchdog stopped");
  property p_pulldown;
    portb_pulldown == ({8{FOB_INIT[1]}} & ~portb_dir) &&
    portc_pulldown == ({8{FOB_INIT[0]}} & ~portc_dir);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down wrong");
  property p_div2; boot_mode |-> osc_div2; endproperty
  a_div2: assert property (p_div2) else $error("no divide by two");
  property p_vector; boot_mode |-> boot_vector == `BMOC_BOOT_VEC; endproperty
  a_vector: assert property (p_vector) else $error("boot vector wrong");
  property p_hs_hold; handshake_line_a && !handshake_line_b |=> handshake_line_a; endproperty
  a_hs_hold: assert property (p_hs_hold) else $error("request dropped");
  property p_fail_halt; $rose(fail_led) |=> fail_led [*4]; endproperty
  a_fail_halt: assert property (p_fail_halt) else $error("error light lost");
  property p_ee_low; ee_req && lat_m_q && ee_req_offset < 8'h20 |-> ee_grant; endproperty
  a_ee_low: assert property (p_ee_low) else $error("lower part refused");
  property p_ee_read; !lat_m_q |-> !ee_grant; endproperty
  a_ee_read: assert property (p_ee_read) else $error("access without latch");
  property p_ee_boot; ee_req && lat_m_q && boot_mode |-> ee_grant; endproperty
  a_ee_boot: assert property (p_ee_boot) else $error("refused in boot");
  c_hold: cover property ($rose(reset_out_n));
  c_copied: cover property (boot_mode && compare_out_one);
  c_fail: cover property ($rose(fail_led));
endmodule : bmoc_monitor
bind bmoc_top bmoc_monitor #(.FOB_INIT(FOB_INIT)) bmoc_monitor_inst (
  .ref_clk, .resetn, .reset_out_n, .wait_mode, .stop_mode, .reg_addr, .reg_wdata, .reg_wr,
  .wdog_enable, .wdog_run, .osc_div2,
  .boot_mode, .boot_vector, .portb_dir, .portc_dir, .portb_pulldown, .portc_pulldown,
  .ee_req, .ee_req_offset, .ee_grant, .handshake_line_a, .handshake_line_b, .fail_led,
  .compare_out_one
);
`default_nettype wire

/* testbench/bmoc_source.sv */
`default_nettype none
module bmoc_source #(
  parameter int DELAY = 2
) (
  // clock
  input wire logic ref_clk,
  // request side
  input wire logic handshake_line_a,
  input wire logic [14:0] src_addr,
  // answer side
  output logic handshake_line_b,
  output logic [7:0] porta_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q = 0;
  initial handshake_line_b = 1'h0;
  initial porta_in = 8'hA5;
  // data first, answer later, release after request drops
  always @(posedge ref_clk) begin
    if (handshake_line_a && !handshake_line_b) begin
      wait_q <= wait_q + 1;
      if (wait_q == 0) porta_in <= src_addr[7:0] ^ src_addr[14:8];
      if (wait_q == DELAY) handshake_line_b <= 1'h1;
    end else if (!handshake_line_a) begin
      handshake_line_b <= 1'h0;
      porta_in <= ~porta_in;
      wait_q <= 0;
    end
  end
endmodule : bmoc_source
`default_nettype wire

/* testbench/bmoc_top_test.sv */
`default_nettype none
`include "bmoc_defs.svh"
module bmoc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FOB = 8'h1B;
  logic ref_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, stop_mode = 1'h0;
  logic wait_mode = 1'h0, ee_req = 1'h0, irq_high_volt = 1'h0, capture_in_one = 1'h0;
  logic mode_sel_one = 1'h0, mode_sel_two = 1'h0, mode_sel_three = 1'h0, mode_sel_four = 1'h0;
  logic [14:0] reg_addr = 15'h0000;
  logic [7:0] reg_wdata = 8'h00, portb_dir = 8'h00, portc_dir = 8'h00, ee_req_offset = 8'h00;
  logic [7:0] mem_rdata = 8'h5A;
  logic reset_out_n, wdog_enable, wdog_run, osc_div2, boot_mode, ram_jump, ee_grant;
  logic handshake_line_a, handshake_line_b, compare_out_one, compare_out_two;
  logic pass_led, fail_led, mem_we, ep_prog, ee_prog, ee_erase;
  logic [14:0] boot_vector, mem_addr;
  logic [7:0] reg_rdata, portb_pulldown, portc_pulldown, porta_in, portb_out, mem_wdata;
  logic [4:0] portc_out;
  logic [3:0] modes [5] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'hC};
  logic [7:0] opt_m = 8'h03;
  logic latch_m = 1'h0;
  int failures = 0, total_checks = 0, cyc = 0, seed = 90026, r, n;
  bmoc_top #(.EE_ERASE_CYC(50), .PROG_CYC(8), .PROG_ALT_CYC(8), .FOB_INIT(FOB)) bmoc_top_inst (
    .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_mode,
    .wait_mode, .reset_out_n, .wdog_enable, .wdog_run, .osc_div2, .boot_mode, .boot_vector,
    .ram_jump, .portb_dir, .portc_dir, .portb_pulldown, .portc_pulldown, .ee_req,
    .ee_req_offset, .ee_grant, .irq_high_volt, .capture_in_one, .mode_sel_one, .mode_sel_two,
    .mode_sel_three, .mode_sel_four, .porta_in, .handshake_line_b, .handshake_line_a,
    .portb_out, .portc_out, .compare_out_one, .compare_out_two, .pass_led, .fail_led,
    .mem_addr, .mem_we, .mem_wdata, .mem_rdata, .ep_prog, .ee_prog, .ee_erase
  );
  bmoc_source #(.DELAY(2)) bmoc_source_inst (
    .ref_clk, .handshake_line_a,
    .src_addr({compare_out_two, compare_out_one, portc_out, portb_out}),
    .handshake_line_b, .porta_in
  );
  always #12.5 ref_clk = ~ref_clk;
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      test_done();
    end
  end
  task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    if (a == `BMOC_CTRL_ADDR) latch_m = d[`BMOC_CTRL_LAT];
    if (a == `BMOC_OPT_ADDR) opt_m = {6'h00, d[1] | (opt_m[1] & !latch_m), d[0]};
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", 15'(exp), 15'(reg_rdata));
  endtask : rd
  task automatic rst(input logic boot, input logic [3:0] pins);
    @(posedge ref_clk);
    resetn <= 1'h0;
    {irq_high_volt, capture_in_one} <= {boot, boot};
    {mode_sel_four, mode_sel_three, mode_sel_two, mode_sel_one} <= pins;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'h1;
    latch_m = 1'h0;
    repeat (3) @(posedge ref_clk);
    {irq_high_volt, capture_in_one} <= 2'h0;
  endtask : rst
  // random directions, offsets and wait; boot is the expected mode
  task automatic mix(input int cnt, input logic boot);
    repeat (cnt) begin
      @(posedge ref_clk);
      r = $random(seed);
      portb_dir <= r[7:0];
      portc_dir <= r[15:8];
      ee_req_offset <= r[23:16];
      wait_mode <= r[24];
      ee_req <= 1'h1;
      @(posedge ref_clk);
      #1 chk("portb_pulldown", 15'(FOB[1] ? 8'(~portb_dir) : 8'h00), 15'(portb_pulldown));
      chk("portc_pulldown", 15'(FOB[0] ? 8'(~portc_dir) : 8'h00), 15'(portc_pulldown));
      chk("wdog_run", 15'(FOB[3] & !boot & (!wait_mode | FOB[2])), 15'(wdog_run));
      chk("ee_grant", 15'(latch_m & (boot | ee_req_offset < 8'h20 | opt_m[1])),
          15'(ee_grant));
    end
  endtask : mix
  initial begin
    rst(1'h0, 4'h0);
    repeat (10) @(posedge ref_clk);
    #1 chk("reset_out_n", 15'h0000, 15'(reset_out_n));
    repeat (10) @(posedge ref_clk);
    #1 chk("reset_out_n", 15'h0001, 15'(reset_out_n));
    rd(`BMOC_FOB_ADDR, FOB);
    wr(`BMOC_FOB_ADDR, ~FOB);
    rd(`BMOC_FOB_ADDR, FOB);
    rd(`BMOC_OPT_ADDR, opt_m);
    rd(15'h0055, 8'h00);
    mix(16, 1'h0);
    wr(`BMOC_OPT_ADDR, 8'h00);
    rd(`BMOC_OPT_ADDR, opt_m);
    wr(`BMOC_CTRL_ADDR, 8'h02);
    @(posedge ref_clk) stop_mode <= 1'h1;
    @(posedge ref_clk) stop_mode <= 1'h0;
    latch_m = 1'h0;
    wr(`BMOC_OPT_ADDR, 8'h00);
    rd(`BMOC_OPT_ADDR, opt_m);
    wr(`BMOC_CTRL_ADDR, 8'h02);
    wr(`BMOC_OPT_ADDR, 8'h01);
    rd(`BMOC_OPT_ADDR, opt_m);
    mix(24, 1'h0);
    foreach (modes[i]) begin
      rst(1'h1, modes[i]);
      #1 chk("boot_mode", 15'h0001, 15'(boot_mode));
      chk("osc_div2", 15'h0001, 15'(osc_div2));
      chk("boot_vector", `BMOC_BOOT_VEC, boot_vector);
      chk("ram_jump", 15'(modes[i][2] & (modes[i][1] | modes[i][3])), 15'(ram_jump));
      if (modes[i] == 4'h8) chk("portc_out", 15'h0001, 15'(portc_out));
      mix(2, 1'h1);
    end
    rst(1'h1, 4'h0);
    wr(`BMOC_CTRL_ADDR, 8'h02);
    wr(`BMOC_OPT_ADDR, 8'h00);
    rd(`BMOC_OPT_ADDR, opt_m);
    mix(8, 1'h1);
    #1 chk("boot_mode", 15'h0001, 15'(boot_mode));
    for (n = 0; n < 4000 && fail_led !== 1'h1; n++) @(posedge ref_clk);
    #1 chk("compare_out_one", 15'h0001, 15'(compare_out_one));
    chk("fail_led", 15'h0001, 15'(fail_led));
    chk("pass_led", 15'h0000, 15'(pass_led));
    rd(`BMOC_STAT_ADDR, 8'h1E);
    rst(1'h1, 4'h0);
    #1 chk("boot_mode", 15'h0000, 15'(boot_mode));
    chk("osc_div2", 15'h0000, 15'(osc_div2));
    rd(`BMOC_STAT_ADDR, 8'h00);
    mix(2, 1'h0);
    test_done();
  end
endmodule : bmoc_top_test
`default_nettype wire
